// ### pkg/rx_snoop_pkg.sv
// Shared constants and carriers for the Ethernet receive snoop port.
// Assumes a 32-bit system bus with big-endian byte lanes (lane 0 = bits 31:24).
package rx_snoop_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int            DATA_W         = 32;
    localparam int            ADDR_W         = 32;
    localparam int            FC_W           = 4;
    localparam int            LEN_W          = 16;
    localparam logic [2:0]    BYTES_PER_WORD = 3'h4;
    localparam logic [31:0]   WORD_STRIDE    = 32'h0000_0004;

    // Byte lane 3 of a big-endian word sits in the low byte
    localparam int            TAG_LANE_LSB   = 0;
    localparam int            TAG_W          = 8;

    // ---------------------------------------------------------------
    // Acknowledge codes on the frame-write acknowledge outputs
    // ---------------------------------------------------------------
    localparam logic [1:0]    ACK_NONE       = 2'h0;
    localparam logic [1:0]    ACK_FIRST      = 2'h1;
    localparam logic [1:0]    ACK_MID        = 2'h2;
    localparam logic [1:0]    ACK_LAST       = 2'h3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0]   LEN_RESET      = 16'h0000;
    localparam logic [31:0]   ADDR_RESET     = 32'h0000_0000;
    localparam logic [7:0]    TAG_RESET      = 8'h00;

    typedef enum logic [1:0] {
        PORT_32,
        PORT_16,
        PORT_8
    } port_width_t;

    // Word as it leaves the receive FIFO
    typedef struct packed {
        logic [31:0] data;
        logic        first;
        logic        last;
        logic [2:0]  nbytes;
    } rx_word_t;

    // One 32-bit write request toward memory
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  fc;
        logic [1:0]  ack;
    } word_req_t;

    // One bus cycle on the system bus
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [2:0]  size;
        logic [3:0]  fc;
    } bus_cycle_t;

endpackage

// ### src/bus_cycle_splitter.sv
// Breaks one 32-bit write into one, two or four bus cycles by port width.
// Assumes the memory side answers each cycle with a one-cycle cyc_done.
`timescale 1ns/1ps
module bus_cycle_splitter
    import rx_snoop_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        word_valid,
    output logic             word_ready,
    input  word_req_t        word,
    input  port_width_t      port_width,
    output logic             cyc_valid,
    output bus_cycle_t       cyc,
    output logic [1:0]       cyc_ack,
    input  wire logic        cyc_done,
    output logic             busy
);

    word_req_t   word_q;
    port_width_t width_q;
    logic        active_q;
    logic [1:0]  idx_q;
    logic [2:0]  step;
    logic [1:0]  last_idx;
    logic [2:0]  offset;
    logic [4:0]  bit_shift;

    // ---------------------------------------------------------------
    // Cycle geometry
    // ---------------------------------------------------------------
    always_comb begin
        case (width_q)
            PORT_32: begin
                step     = 3'h4;
                last_idx = 2'h0;
            end
            PORT_16: begin
                step     = 3'h2;
                last_idx = 2'h1;
            end
            PORT_8: begin
                step     = 3'h1;
                last_idx = 2'h3;
            end
            default: begin
                step     = 3'h4;
                last_idx = 2'h0;
            end
        endcase
        offset    = 3'(step * {1'b0, idx_q});
        bit_shift = {offset[1:0], 3'h0};
    end

    assign word_ready = !active_q;
    assign busy       = active_q;
    assign cyc_valid  = active_q;
    // Code held from the latched word, so every cycle of the word shows it
    assign cyc_ack    = active_q ? word_q.ack : ACK_NONE;

    always_comb begin
        cyc.addr = word_q.addr + {29'h0, offset};
        // Narrow ports take their bytes on the upper lanes
        cyc.data = word_q.data << bit_shift;
        cyc.size = 3'(BYTES_PER_WORD - offset);
        cyc.fc   = word_q.fc;
    end

    // ---------------------------------------------------------------
    // Sequencing
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
            idx_q    <= 2'h0;
            word_q   <= '0;
            width_q  <= PORT_32;
        end else if (!active_q) begin
            if (word_valid) begin
                active_q <= 1'b1;
                idx_q    <= 2'h0;
                word_q   <= word;
                width_q  <= port_width;
            end
        end else if (cyc_done) begin
            if (idx_q == last_idx) begin
                active_q <= 1'b0;
            end else begin
                idx_q <= idx_q + 2'h1;
            end
        end
    end

endmodule

// ### src/ethernet_rx_cam_snoop_port.sv
// Ethernet receive write path with the parallel CAM snoop outputs.
// Assumes the receiver hands over FIFO words with first/last marks and byte
// counts, and pulses fcs_byte_read when the last FCS byte leaves the FIFO.
//
// Functional notes
// - With tag insert enabled, tag byte goes out in the final frame write.
// - Tag pins sampled when the last FCS byte leaves the receive FIFO.
// - Acknowledge outputs asserted on every received frame data write except a short final one.
// - Acknowledge outputs stay zero for other protocol traffic.
// - Acknowledge valid on each bus cycle of a 32-bit write, receiver only.
// - First-word code on first write, distinct mid code on middle writes.
// - Third code marks the final write, only when a tag is appended.
// - Tag always sits in byte lane 3 of the final write.
// - Descriptor data length excludes the appended tag byte.
// - Acknowledge reads 00 on the final write when frame length is not a multiple of four.
// - One, two or four bus cycles per word for 32, 16, 8-bit memory.
// - Software-chosen function code marks receive DMA accesses.
`timescale 1ns/1ps
module ethernet_rx_cam_snoop_port
    import rx_snoop_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Configuration
    input  wire logic        tag_insert_enable,
    input  port_width_t      port_width,
    input  wire logic [3:0]  rx_function_code,
    // Receive FIFO side
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  rx_word_t         rx_word,
    input  wire logic [31:0] rx_buf_addr,
    input  wire logic        fcs_byte_read,
    // Tag pins from the CAM logic
    input  wire logic [7:0]  tag_input_pins,
    // Other channels sharing the bus
    input  wire logic        other_valid,
    output logic             other_ready,
    input  word_req_t        other_req,
    // System bus
    output logic             bus_valid,
    output bus_cycle_t       bus_cycle,
    input  wire logic        bus_done,
    output logic [1:0]       rx_frame_write_ack,
    // Receive buffer descriptor close-out
    output logic             bd_valid,
    output logic [15:0]      bd_length
);

    typedef enum logic [1:0] {
        ST_RECEIVE,
        ST_TAG,
        ST_CLOSE
    } rx_state_t;

    rx_state_t   state_q;
    logic [7:0]  tag_meta_q;
    logic [7:0]  tag_sync_q;
    logic [7:0]  tag_q;
    logic [7:0]  tag_now;
    logic [31:0] addr_q;
    logic [15:0] len_q;
    logic        pend_valid_q;
    word_req_t   pend_q;
    logic        bd_valid_q;
    logic [15:0] bd_length_q;

    logic        spl_valid;
    logic        spl_ready;
    word_req_t   spl_word;
    logic        spl_busy;
    logic        rx_take;
    logic        tag_load;
    logic [31:0] word_addr;
    logic [15:0] len_next;
    logic        aligned;
    logic        tag_extra;
    word_req_t   rx_req;

    // ---------------------------------------------------------------
    // Tag pin capture
    // ---------------------------------------------------------------
    // Pins come from outside logic; only the second stage is read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tag_meta_q <= TAG_RESET;
            tag_sync_q <= TAG_RESET;
        end else begin
            tag_meta_q <= tag_input_pins;
            tag_sync_q <= tag_meta_q;
        end
    end

    // Sample taken on the last FCS byte; the CAM side holds it until used
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tag_q <= TAG_RESET;
        end else if (fcs_byte_read) begin
            tag_q <= tag_sync_q;
        end
    end

    // Sample and last word may coincide
    assign tag_now = fcs_byte_read ? tag_sync_q : tag_q;

    // ---------------------------------------------------------------
    // Word build
    // ---------------------------------------------------------------
    assign rx_ready = (state_q == ST_RECEIVE) && (!pend_valid_q || spl_ready);
    assign rx_take  = rx_valid && rx_ready;
    assign tag_load = (state_q == ST_TAG) && (!pend_valid_q || spl_ready);

    always_comb begin
        word_addr = rx_word.first ? rx_buf_addr : addr_q;
        len_next  = (rx_word.first ? LEN_RESET : len_q) + {13'h0, rx_word.nbytes};
        aligned   = (len_next[1:0] == 2'h0);
        tag_extra = rx_word.last && tag_insert_enable && aligned;

        rx_req.addr = word_addr;
        rx_req.data = rx_word.data;
        rx_req.fc   = rx_function_code;
        if (rx_word.last && tag_insert_enable && !aligned) begin
            // Unused lane 3 of a short final word carries the tag
            rx_req.data[TAG_LANE_LSB +: TAG_W] = tag_now;
        end

        if (rx_word.last && !aligned) begin
            rx_req.ack = ACK_NONE;
        end else if (rx_word.first) begin
            rx_req.ack = ACK_FIRST;
        end else begin
            rx_req.ack = ACK_MID;
        end
    end

    // ---------------------------------------------------------------
    // Frame state
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RECEIVE;
        end else begin
            case (state_q)
                ST_RECEIVE: begin
                    if (rx_take && rx_word.last) begin
                        state_q <= tag_extra ? ST_TAG : ST_CLOSE;
                    end
                end
                ST_TAG: begin
                    if (tag_load) begin
                        state_q <= ST_CLOSE;
                    end
                end
                ST_CLOSE: begin
                    // Close only once the final write has left the bus
                    if (!pend_valid_q && !spl_busy) begin
                        state_q <= ST_RECEIVE;
                    end
                end
                default: begin
                    state_q <= ST_RECEIVE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q <= ADDR_RESET;
            len_q  <= LEN_RESET;
        end else if (rx_take) begin
            addr_q <= word_addr + WORD_STRIDE;
            len_q  <= len_next;
        end
    end

    // ---------------------------------------------------------------
    // Pending write slot
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_valid_q <= 1'b0;
            pend_q       <= '0;
        end else if (rx_take) begin
            pend_valid_q <= 1'b1;
            pend_q       <= rx_req;
        end else if (tag_load) begin
            // Extra word holds only the tag, in lane 3
            pend_valid_q <= 1'b1;
            pend_q.addr  <= addr_q;
            pend_q.data  <= {24'h00_0000, tag_q};
            pend_q.fc    <= rx_function_code;
            pend_q.ack   <= ACK_LAST;
        end else if (spl_ready) begin
            pend_valid_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Bus arbitration
    // ---------------------------------------------------------------
    // Receive writes win; a FIFO overrun costs more than a stalled channel
    assign spl_valid   = pend_valid_q || other_valid;
    assign other_ready = !pend_valid_q && spl_ready;

    always_comb begin
        if (pend_valid_q) begin
            spl_word = pend_q;
        end else begin
            spl_word     = other_req;
            spl_word.ack = ACK_NONE;
        end
    end

    bus_cycle_splitter u_splitter (
        .core_clk   (core_clk),
        .rst        (rst),
        .word_valid (spl_valid),
        .word_ready (spl_ready),
        .word       (spl_word),
        .port_width (port_width),
        .cyc_valid  (bus_valid),
        .cyc        (bus_cycle),
        .cyc_ack    (rx_frame_write_ack),
        .cyc_done   (bus_done),
        .busy       (spl_busy)
    );

    // ---------------------------------------------------------------
    // Descriptor close-out
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bd_valid_q  <= 1'b0;
            bd_length_q <= LEN_RESET;
        end else begin
            bd_valid_q <= (state_q == ST_CLOSE) && !pend_valid_q && !spl_busy;
            if ((state_q == ST_CLOSE) && !pend_valid_q && !spl_busy) begin
                // Frame bytes only; the appended tag is never counted
                bd_length_q <= len_q;
            end
        end
    end

    assign bd_valid  = bd_valid_q;
    assign bd_length = bd_length_q;

endmodule

// ### testbench/ethernet_rx_cam_snoop_port_sva.sv
// Bus-side assertions for the receive snoop port.
// Assumes other traffic never carries the receive function code.
`timescale 1ns/1ps
module ethernet_rx_cam_snoop_port_sva
    import rx_snoop_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input port_width_t      port_width,
    input wire logic [3:0]  rx_function_code,
    input wire logic        bus_valid,
    input bus_cycle_t       bus_cycle,
    input wire logic        bus_done,
    input wire logic [1:0]  rx_frame_write_ack,
    input wire logic        bd_valid,
    input wire logic [15:0] bd_length
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ack_idle: assert property (!bus_valid |-> rx_frame_write_ack == ACK_NONE)
        else $error("ack active without a bus cycle");
    a_ack_hold: assert property (bus_valid && !bus_done |=> bus_valid
        && $stable(rx_frame_write_ack) && $stable(bus_cycle))
        else $error("bus cycle or ack moved before done");
    a_foreign_quiet: assert property (bus_valid && bus_cycle.fc != rx_function_code
        |-> rx_frame_write_ack == ACK_NONE)
        else $error("ack on foreign traffic");
    a_rx_fc: assert property (bus_valid && rx_frame_write_ack != ACK_NONE
        |-> bus_cycle.fc == rx_function_code)
        else $error("acked cycle lacks receive function code");
    a_half_step: assert property (bus_valid && bus_done && port_width == PORT_16
        && bus_cycle.size == 3'h4 |=> bus_valid
        && bus_cycle.addr == $past(bus_cycle.addr) + 32'h0000_0002
        && rx_frame_write_ack == $past(rx_frame_write_ack))
        else $error("16-bit second cycle wrong");
    a_byte_step: assert property (bus_valid && bus_done && port_width == PORT_8
        && bus_cycle.size == 3'h4 |=> bus_valid && bus_cycle.size == 3'h3
        && bus_cycle.addr == $past(bus_cycle.addr) + 32'h0000_0001)
        else $error("8-bit second cycle wrong");
    a_last_lane: assert property (bus_valid && rx_frame_write_ack == ACK_LAST
        && port_width == PORT_32 |-> bus_cycle.data[31:8] == 24'h00_0000)
        else $error("tag word has bytes outside lane 3");
    a_bd_pulse: assert property (bd_valid |=> !bd_valid)
        else $error("descriptor close longer than one cycle");
    a_len_close: assert property ($changed(bd_length) |-> bd_valid)
        else $error("length moved outside a close");

    c_first: cover property (bus_valid && bus_done && rx_frame_write_ack == ACK_FIRST);
    c_last: cover property (bus_valid && bus_done && rx_frame_write_ack == ACK_LAST);
    c_byte: cover property (bus_valid && bus_done && port_width == PORT_8);
    c_close: cover property (bd_valid);
endmodule

// ### testbench/cam_bus_partner.sv
// Memory responder and CAM tag source on the far side of the port.
// Assumes the bench loads the tag at frame start.
`timescale 1ns/1ps
module cam_bus_partner
    import rx_snoop_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic       bus_valid,
    input  wire logic [1:0] rx_frame_write_ack,
    input  wire logic       bd_valid,
    input  wire logic       tag_load,
    input  wire logic [7:0] tag_value,
    output logic            bus_done,
    output logic [7:0]      tag_input_pins
);
    logic [1:0] wait_q;
    logic [7:0] tag_q;
    logic       held_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_done <= 1'b0;
            wait_q   <= 2'h0;
        end else if (bus_done) begin
            bus_done <= 1'b0;
            wait_q   <= slow ? 2'($urandom_range(3)) : 2'h0;
        end else if (bus_valid && wait_q == 2'h0) begin
            bus_done <= 1'b1;
        end else if (bus_valid) begin
            wait_q <= wait_q - 2'h1;
        end
    end

    // Tag held from frame start until its write is acked or the frame closes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tag_q  <= 8'h00;
            held_q <= 1'b0;
        end else if (tag_load) begin
            tag_q  <= tag_value;
            held_q <= 1'b1;
        end else if (bd_valid || (bus_done && rx_frame_write_ack == ACK_LAST)) begin
            held_q <= 1'b0;
        end
    end
    // Released pins show garbage, never the stale tag
    assign tag_input_pins = held_q ? tag_q : ~tag_q;
endmodule

// ### testbench/test_ethernet_rx_cam_snoop_port.sv
// Self-checking bench: random frames on all port widths, tag on and off.
// Assumes the partner answers bus cycles and drives the tag pins.
`timescale 1ns/1ps
module test_ethernet_rx_cam_snoop_port;
    import rx_snoop_pkg::*;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0]  ack;
    } exp_t;

    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        tag_insert_enable = 1'b0;
    port_width_t port_width = PORT_32;
    logic [3:0]  rx_function_code = 4'h1;
    logic        rx_valid = 1'b0;
    logic        rx_ready;
    rx_word_t    rx_word = '0;
    logic [31:0] rx_buf_addr = 32'h0000_0000;
    logic        fcs_byte_read = 1'b0;
    logic [7:0]  tag_input_pins;
    logic        other_valid = 1'b0;
    logic        other_ready;
    word_req_t   other_req = '0;
    logic        bus_valid, bus_done, bd_valid, slow = 1'b0, tag_load = 1'b0;
    bus_cycle_t  bus_cycle;
    logic [1:0]  rx_frame_write_ack;
    logic [15:0] bd_length;
    logic [7:0]  tag_value = 8'h00;
    int          err_total = 0, cmp_count = 0, cyc = 0, len;
    int          corner[7] = '{8, 5, 4, 3, 1, 12, 16};
    exp_t        exp_q[$], got_q[$];

    always #5 core_clk = ~core_clk;

    ethernet_rx_cam_snoop_port uut (.core_clk(core_clk), .rst(rst),
        .tag_insert_enable(tag_insert_enable), .port_width(port_width),
        .rx_function_code(rx_function_code), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_word(rx_word), .rx_buf_addr(rx_buf_addr), .fcs_byte_read(fcs_byte_read),
        .tag_input_pins(tag_input_pins), .other_valid(other_valid),
        .other_ready(other_ready), .other_req(other_req), .bus_valid(bus_valid),
        .bus_cycle(bus_cycle), .bus_done(bus_done),
        .rx_frame_write_ack(rx_frame_write_ack), .bd_valid(bd_valid), .bd_length(bd_length));

    cam_bus_partner far_end (.core_clk(core_clk), .rst(rst), .slow(slow),
        .bus_valid(bus_valid), .rx_frame_write_ack(rx_frame_write_ack),
        .bd_valid(bd_valid), .tag_load(tag_load), .tag_value(tag_value),
        .bus_done(bus_done), .tag_input_pins(tag_input_pins));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected bus cycles of one word on the current port width
    task automatic add_word(input logic [31:0] a, d, m, input logic [1:0] ack);
        int   step;
        exp_t e;
        step = (port_width == PORT_32) ? 4 : (port_width == PORT_16) ? 2 : 1;
        for (int k = 0; k < 4 / step; k++) begin
            e.addr = a + 32'(k * step);
            e.data = d << (8 * k * step);
            e.mask = (m << (8 * k * step)) & ~(32'hFFFF_FFFF >> (8 * step));
            e.ack  = ack;
            exp_q.push_back(e);
        end
    endtask

    always @(negedge core_clk) begin
        if (!rst && bus_valid && bus_done) begin
            if (bus_cycle.fc === rx_function_code)
                got_q.push_back({bus_cycle.addr, bus_cycle.data, 32'h0, rx_frame_write_ack});
            else check(32'(rx_frame_write_ack), 32'(ACK_NONE));
        end
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic send_frame(input int len);
        int          n, nb;
        logic [31:0] w, d, m, base;
        logic [7:0]  tg;
        n = (len + 3) / 4;
        base = $urandom & 32'hFFFF_FFFC;
        tg = 8'($urandom);
        exp_q.delete();
        got_q.delete();
        @(posedge core_clk);
        tag_value <= tg;
        tag_load <= 1'b1;
        rx_buf_addr <= base;
        @(posedge core_clk);
        tag_load <= 1'b0;
        // Tag must clear the two-flop pin synchroniser before the last word
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            nb = (i == n - 1) ? len - 4 * i : 4;
            w = $urandom;
            m = ~(32'hFFFF_FFFF >> (8 * nb));
            d = w;
            if (i == n - 1 && len % 4 != 0 && tag_insert_enable) begin
                d[7:0] = tg;
                m[7:0] = 8'hFF;
            end
            add_word(base + 32'(4 * i), d, m, (i == n - 1 && len % 4 != 0) ? ACK_NONE :
                     (i == 0) ? ACK_FIRST : ACK_MID);
            rx_valid <= 1'b1;
            rx_word <= {w, i == 0, i == n - 1, 3'(nb)};
            // Last FCS byte leaves the FIFO with the final word
            fcs_byte_read <= (i == n - 1);
            do @(negedge core_clk); while (rx_ready !== 1'b1);
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        fcs_byte_read <= 1'b0;
        if (tag_insert_enable && len % 4 == 0)
            add_word(base + 32'(4 * n), {24'h00_0000, tg}, 32'hFFFF_FFFF, ACK_LAST);
        for (int k = 0; k < 400 && bd_valid !== 1'b1; k++) @(negedge core_clk);
        check(32'(bd_valid), 32'h1);
        check(32'(bd_length), 32'(len));
        check(got_q.size(), exp_q.size());
        foreach (exp_q[i]) begin
            if (i < got_q.size()) begin
                check(got_q[i].addr, exp_q[i].addr);
                check(got_q[i].data & exp_q[i].mask, exp_q[i].data & exp_q[i].mask);
                check(32'(got_q[i].ack), 32'(exp_q[i].ack));
            end
        end
    endtask

    // Competing channel; its ack field must never reach the outputs
    task automatic send_other(input int cnt);
        @(posedge core_clk);
        repeat (cnt) begin
            other_valid <= 1'b1;
            other_req <= {$urandom, $urandom, rx_function_code ^ 4'h8, ACK_LAST};
            do @(negedge core_clk); while (other_ready !== 1'b1);
            @(posedge core_clk);
        end
        other_valid <= 1'b0;
    endtask

    initial begin
        void'($urandom(83895));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int t = 0; t < 18; t++) begin
            // Width changes only once the previous test's last word has left the bus
            do @(negedge core_clk); while (bus_valid !== 1'b0);
            @(posedge core_clk);
            port_width <= port_width_t'(t % 3);
            tag_insert_enable <= t[1];
            slow <= t[0];
            rx_function_code <= 4'($urandom_range(7));
            len = (t < 7) ? corner[t] : $urandom_range(1, 24);
            fork
                send_frame(len);
                if (t[2]) send_other(3);
            join
            $display("test %0d done, length %0d", t, len);
        end
        report_and_stop();
    end
endmodule

bind ethernet_rx_cam_snoop_port ethernet_rx_cam_snoop_port_sva checker_i (
    .core_clk(core_clk), .rst(rst), .port_width(port_width),
    .rx_function_code(rx_function_code), .bus_valid(bus_valid), .bus_cycle(bus_cycle),
    .bus_done(bus_done), .rx_frame_write_ack(rx_frame_write_ack), .bd_valid(bd_valid),
    .bd_length(bd_length));
